//--- verilog/iword_defines.vh
// register offsets, field positions, reset values and cycle counts
// for the instruction word decoder; shared by the decoder and its bench
`ifndef IWORD_DEFINES_VH
`define IWORD_DEFINES_VH

// apb byte offsets
`define OFS_INSTR       8'h00
`define OFS_FLAGS       8'h04
`define OFS_DEC_CTRL    8'h08
`define OFS_DEC_OPND    8'h0c
`define OFS_DEC_LIT     8'h10
`define OFS_DEC_PADDR   8'h14
`define OFS_DEC_DSP     8'h18

// instruction word fields
`define WORD_W          24
`define OPC_MSB         23
`define OPC_LSB         16

// opcode values and ranges
`define OPC_NOP         8'h00
`define OPC_GOTO        8'h02
`define OPC_CALL        8'h03
`define OPC_TBLRD       8'h06
`define OPC_PSVRD       8'h07
`define OPC_BRA_LO      8'h08
`define OPC_SKIP_LO     8'h10
`define OPC_WOP_LO      8'h20
`define OPC_FILE_LO     8'h40
`define OPC_BIT_LO      8'h60
`define OPC_LIT_LO      8'h70
`define OPC_DMOV        8'h78
`define OPC_MAC_LO      8'h80
`define OPC_DSP_LO      8'h90
`define OPC_DSP_HI      8'h9f

// literal limits
`define LIT10_BYTE_MAX  10'h0ff

// data size codes
`define SZ_WORD         2'h0
`define SZ_BYTE         2'h1
`define SZ_DWORD        2'h2

// status flag bit positions
`define FL_CARRY        0
`define FL_NIBBLE       1
`define FL_NEG          2
`define FL_RANGE        3
`define FL_ZERO         4
`define FL_ACCA_OV      5
`define FL_ACCB_OV      6
`define FL_ACCA_CLIP    7
`define FL_ACCB_CLIP    8
`define FLAGS_RST       9'h000

// flags touched per class
`define AFF_MCU         9'h01f
`define AFF_BIT         9'h010
`define AFF_ACC_A       9'h0a0
`define AFF_ACC_B       9'h140

// instruction cycle counts
`define CYC_ONE         2'h1
`define CYC_TWO         2'h2
`define CYC_THREE       2'h3

`endif

//--- verilog/instruction_word_decoder.v
// instruction word decoder with apb register access
// assumes an apb master on pclk; software writes fetched words in order
// one clock, asynchronous active-low reset; no input needs synchronising
//
// The address map and the APB register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "iword_defines.vh"

// Summary of operation
// - a single word is 24 bits, top 8 bits select the instruction type
// - goto and call span two consecutive 24-bit words, 48 bits in all
// - second word has zero top byte; alone it decodes as a no-op
// - every two-word instruction is reported as two cycles
// - one cycle, plus one for true condition, pc change, table or view read
// - a taken skip costs two cycles, three over a two-word instruction
// - double-word moves take two cycles
// - three-operand form: plain base, source and destination with modes
// - file form: file address plus destination file or working reg zero
// - file address covers data space 0 to 0x1fff
// - bit number from 4-bit literal or from a base working register
// - accumulator a or b selected, each with own overflow and clip flags
// - write-back goes to w13 or to [w13] then w13 plus two
// - five mcu flags kept: carry, nibble carry, negative, range, zero
// - 10-bit literal max 255 in byte mode, 1023 word; signed -512..511
// - program address literal must have bit zero clear
// - mac form: accumulator, two multiplicands, x/y prefetch, write-back
// - other dsp form: accumulator, operand with mode, shift reg or literal
// - byte, word, double-word sizes, word default, plus shadow select
// - x prefetch: w8/w9 with +-2/4/6, none, w9+w12, or no prefetch
// - multiplicands distinct pairs of w4..w7, or squares of one of them
module instruction_word_decoder (
	input  wire        pclk,    // apb clock, 100 mhz
	input  wire        presetn, // async reset, active low
	input  wire        psel,    // slave select
	input  wire        penable, // access phase
	input  wire        pwrite,  // 1 write, 0 read
	input  wire [7:0]  paddr,   // byte address
	input  wire [31:0] pwdata,  // write data
	output reg  [31:0] prdata,  // read data
	output reg         pready,  // transfer done
	output reg         pslverr  // unmapped address
);

	localparam ST_IDLE  = 2'h0;
	localparam ST_WORD2 = 2'h1;
	localparam ST_SKIP  = 2'h2;
	localparam ST_SKIP2 = 2'h3;

	localparam CL_NOP  = 4'h0;
	localparam CL_CTRL = 4'h1;
	localparam CL_BRA  = 4'h2;
	localparam CL_SKIP = 4'h3;
	localparam CL_WOP  = 4'h4;
	localparam CL_FILE = 4'h5;
	localparam CL_BIT  = 4'h6;
	localparam CL_LIT  = 4'h7;
	localparam CL_DMOV = 4'h8;
	localparam CL_MAC  = 4'h9;
	localparam CL_DSP  = 4'ha;
	localparam CL_ILL  = 4'hf;

	// condition select: 0 always, else one status flag
	function flag_test;
		input [2:0] sel;
		input [8:0] fl;
		begin
			case (sel)
				3'h0:    flag_test = 1'b1;
				3'h1:    flag_test = fl[`FL_CARRY];
				3'h2:    flag_test = fl[`FL_ZERO];
				3'h3:    flag_test = fl[`FL_NEG];
				3'h4:    flag_test = fl[`FL_RANGE];
				3'h5:    flag_test = fl[`FL_NIBBLE];
				3'h6:    flag_test = fl[`FL_ACCA_OV];
				default: flag_test = fl[`FL_ACCB_OV];
			endcase
		end
	endfunction

	// prefetch code -> {active, upper reg, +w12 index, signed step}
	function [6:0] pf_decode;
		input [3:0] c;
		reg   [3:0] st;
		begin
			st = 4'h0;
			case (c[2:0])
				3'h2:    st = 4'h2;
				3'h3:    st = 4'h4;
				3'h4:    st = 4'h6;
				3'h5:    st = 4'he;
				3'h6:    st = 4'hc;
				3'h7:    st = 4'ha;
				default: st = 4'h0;
			endcase
			pf_decode = {(c != 4'h0), c[3], (c == 4'h8), st};
		end
	endfunction

	// multiplicand code -> {legal, first, second} as offsets from w4
	function [4:0] pair_decode;
		input       sq;
		input [2:0] c;
		begin
			if (sq)
				pair_decode = {1'b1, c[1:0], c[1:0]};
			else
				case (c)
					3'h0:    pair_decode = 5'h11;
					3'h1:    pair_decode = 5'h12;
					3'h2:    pair_decode = 5'h13;
					3'h3:    pair_decode = 5'h16;
					3'h4:    pair_decode = 5'h17;
					3'h5:    pair_decode = 5'h1b;
					default: pair_decode = 5'h00;
				endcase
		end
	endfunction

	reg  [1:0]  state_r;
	reg  [8:0]  flags_r;
	reg  [23:0] instr_r;
	reg  [15:0] first_lo_r;
	reg  [31:0] ctrl_r;
	reg  [31:0] opnd_r;
	reg  [31:0] lit_r;
	reg  [31:0] paddr_r;
	reg  [31:0] dsp_r;

	wire [23:0] w   = pwdata[`WORD_W-1:0];
	wire [7:0]  opc = w[`OPC_MSB:`OPC_LSB];
	wire        wr_done = psel & penable & pready & pwrite;
	wire        ld_instr = wr_done & (paddr == `OFS_INSTR);
	wire        ld_flags = wr_done & (paddr == `OFS_FLAGS);
	wire        two_word = (opc == `OPC_GOTO) | (opc == `OPC_CALL);

	reg  [3:0]  d_class;
	reg  [1:0]  d_size;
	reg         d_shadow;
	reg         d_acc;
	reg         d_ill;
	reg         d_cond;
	reg         d_pcchg;
	reg  [1:0]  d_cyc;
	reg  [8:0]  d_aff;
	reg  [31:0] d_opnd;
	reg  [15:0] d_lit;
	reg  [31:0] d_dsp;
	reg  [4:0]  d_pair;

	always @*
	begin
		d_class  = CL_ILL;
		d_size   = `SZ_WORD;
		d_shadow = 1'b0;
		d_acc    = 1'b0;
		d_ill    = 1'b0;
		d_cond   = 1'b0;
		d_pcchg  = 1'b0;
		d_cyc    = `CYC_ONE;
		d_aff    = 9'h000;
		d_opnd   = 32'h0000_0000;
		d_lit    = 16'h0000;
		d_dsp    = 32'h0000_0000;
		d_pair   = pair_decode(opc[1], w[14:12]);
		if (opc == `OPC_NOP)
			d_class = CL_NOP;
		else if (opc < `OPC_BRA_LO)
		begin
			d_class = CL_CTRL;
			if (two_word)
			begin
				d_cyc   = `CYC_TWO;
				d_pcchg = 1'b1;
			end
			else if (opc == `OPC_TBLRD || opc == `OPC_PSVRD)
				d_cyc = `CYC_TWO;
			else
				d_ill = 1'b1;
		end
		else if (opc < `OPC_SKIP_LO)
		begin
			d_class = CL_BRA;
			d_cond  = flag_test(opc[2:0], flags_r);
			d_pcchg = d_cond;
			d_lit   = w[15:0];
			if (d_cond)
				d_cyc = `CYC_TWO;
		end
		else if (opc < `OPC_WOP_LO)
		begin
			d_class = CL_SKIP;
			d_ill   = opc[3];
			d_cond  = flag_test(opc[2:0], flags_r);
			if (d_cond)
				d_cyc = `CYC_TWO;
		end
		else if (opc < `OPC_FILE_LO || opc == `OPC_DMOV)
		begin
			d_class  = (opc == `OPC_DMOV) ? CL_DMOV : CL_WOP;
			d_size   = (opc == `OPC_DMOV) ? `SZ_DWORD : opc[1:0];
			d_shadow = w[7];
			// code 3 names no size; report word and flag it
			if (d_size == 2'h3)
			begin
				d_ill  = 1'b1;
				d_size = `SZ_WORD;
			end
			d_opnd   = {14'h0000, opc[4:2], w[3:0], w[6:4], w[11:8],
				w[15:12]};
			d_aff    = (opc == `OPC_DMOV) ? 9'h000 : `AFF_MCU;
			if (opc == `OPC_DMOV)
				d_cyc = `CYC_TWO;
		end
		else if (opc < `OPC_BIT_LO)
		begin
			d_class = CL_FILE;
			d_size  = opc[0] ? `SZ_BYTE : `SZ_WORD;
			// 13-bit field: file address cannot pass 0x1fff
			d_lit   = {3'h0, w[12:0]};
			d_opnd  = {13'h0000, w[13], 18'h00000};
			d_aff   = `AFF_MCU;
		end
		else if (opc < `OPC_LIT_LO)
		begin
			d_class = CL_BIT;
			// bit number or base register shows in [22:19] and [3:0]
			d_opnd  = {8'h00, opc[0], w[15:12], 8'h00, w[6:4],
				w[3:0], w[15:12]};
			d_aff   = `AFF_BIT;
		end
		else if (opc < `OPC_DMOV)
		begin
			d_class = CL_LIT;
			d_size  = opc[0] ? `SZ_BYTE : `SZ_WORD;
			d_opnd  = {17'h00000, w[3:0], 11'h000};
			if (opc[1])
				d_lit = {{6{w[13]}}, w[13:4]};
			else
				d_lit = {6'h00, w[13:4]};
			d_ill   = opc[0] & ~opc[1] & (w[13:4] > `LIT10_BYTE_MAX);
			d_aff   = `AFF_MCU;
		end
		else if (opc < `OPC_MAC_LO)
			d_class = CL_ILL;
		else if (opc < `OPC_DSP_LO)
		begin
			d_class = CL_MAC;
			d_acc   = opc[0];
			d_ill   = ~d_pair[4] | (w[1:0] == 2'h3) | w[15];
			d_dsp   = {8'h00, w[1:0],
				opc[3:2], pf_decode(w[5:2]), w[7:6],
				pf_decode(w[11:8]), d_pair[1:0], d_pair[3:2]};
			d_aff   = opc[0] ? `AFF_ACC_B : `AFF_ACC_A;
		end
		else if (opc <= `OPC_DSP_HI)
		begin
			d_class = CL_DSP;
			d_acc   = opc[0];
			d_opnd  = {18'h00000, w[6:4], w[3:0], 7'h00};
			d_dsp   = {3'h0, w[11:8], opc[1], 24'h000000};
			d_lit   = {{10{w[12]}}, w[12:7]};
			d_aff   = opc[0] ? `AFF_ACC_B : `AFF_ACC_A;
		end
	end

	// decode state and registers
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_r    <= ST_IDLE;
			flags_r    <= `FLAGS_RST;
			instr_r    <= 24'h000000;
			first_lo_r <= 16'h0000;
			ctrl_r     <= 32'h0000_0000;
			opnd_r     <= 32'h0000_0000;
			lit_r      <= 32'h0000_0000;
			paddr_r    <= 32'h0000_0000;
			dsp_r      <= 32'h0000_0000;
		end
		else
		begin
			// software owns the flags; no hardware set can race a write
			if (ld_flags)
				flags_r <= pwdata[8:0];
			if (ld_instr)
			begin
				instr_r <= w;
				case (state_r)
					ST_IDLE:
					begin
						ctrl_r  <= {6'h00, d_aff, d_pcchg, d_cond, 2'h0,
							d_ill, d_cyc, two_word, ~two_word, d_acc,
							d_shadow, d_size, d_class};
						opnd_r  <= d_opnd;
						lit_r   <= {16'h0000, d_lit};
						dsp_r   <= d_dsp;
						first_lo_r <= w[15:0];
						if (two_word)
							state_r <= ST_WORD2;
						// an illegal skip opcode must not swallow a word
						else if (d_class == CL_SKIP && d_cond && !d_ill)
							state_r <= ST_SKIP;
					end
					ST_WORD2:
					begin
						// odd target or nonzero upper bits mark it illegal
						paddr_r   <= {9'h000, w[6:0], first_lo_r};
						ctrl_r[12] <= ctrl_r[12] | first_lo_r[0] |
							(opc != `OPC_NOP) | (w[15:7] != 9'h000);
						state_r   <= ST_IDLE;
					end
					ST_SKIP:
					begin
						// skipped word is not decoded, only sized
						if (two_word)
						begin
							ctrl_r[11:10] <= `CYC_THREE;
							state_r       <= ST_SKIP2;
						end
						else
							state_r <= ST_IDLE;
					end
					ST_SKIP2:
						// second half of a skipped two-word instruction
						state_r <= ST_IDLE;
					default: state_r <= ST_IDLE;
				endcase
			end
		end
	end

	// apb slave: one wait state, ready and data from flops
	// ready drops after one cycle so each access waits exactly once
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready  <= 1'b0;
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end
		else
		begin
			pready  <= psel & penable & ~pready;
			pslverr <= 1'b0;
			if (psel & penable & ~pready)
			begin
				prdata <= 32'h0000_0000;
				case (paddr)
					`OFS_INSTR:     prdata <= {8'h00, instr_r};
					`OFS_FLAGS:     prdata <= {23'h000000, flags_r};
					`OFS_DEC_CTRL:  prdata <= {ctrl_r[31:14],
						(state_r != ST_IDLE), ctrl_r[12:0]};
					`OFS_DEC_OPND:  prdata <= opnd_r;
					`OFS_DEC_LIT:   prdata <= lit_r;
					`OFS_DEC_PADDR: prdata <= paddr_r;
					`OFS_DEC_DSP:   prdata <= dsp_r;
					default:        pslverr <= 1'b1;
				endcase
			end
		end
	end

endmodule // instruction_word_decoder
`default_nettype wire

//--- tb/iword_monitor.sv
// checker on the decoder apb port: decoded control fields
// assumes binding to the decoder; sees its ports only
`timescale 1ns/1ps
`default_nettype none
`include "iword_defines.vh"
module iword_monitor (
	input wire logic        pclk,    // clock
	input wire logic        presetn, // reset
	input wire logic        psel,    // select
	input wire logic        penable, // access
	input wire logic        pwrite,  // write
	input wire logic [7:0]  paddr,   // address
	input wire logic [31:0] pwdata,  // wdata
	input wire logic [31:0] prdata,  // rdata
	input wire logic        pready,  // done
	input wire logic        pslverr  // error
);
	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	wire       rd  = pready && psel && !pwrite;
	wire       ctl = rd && paddr == `OFS_DEC_CTRL;
	wire [3:0] cls = prdata[3:0];
	wire [1:0] cyc = prdata[11:10];
	property p_top;
		rd && paddr == `OFS_INSTR |-> prdata[31:24] == 8'h0;
	endproperty
	a_top: assert property (p_top) else $error("instr top");
	property p_flg;
		rd && paddr == `OFS_FLAGS |-> prdata[31:9] == 23'h0;
	endproperty
	a_flg: assert property (p_flg) else $error("flag width");
	property p_two;
		ctl && prdata[9] |-> cyc == `CYC_TWO;
	endproperty
	a_two: assert property (p_two) else $error("two word");
	property p_cyc;
		ctl && (prdata[8] || prdata[9]) |-> cyc != 2'h0;
	endproperty
	a_cyc: assert property (p_cyc) else $error("no cycles");
	property p_nop;
		ctl && prdata[8] && cls == 4'h0 |->
			cyc == `CYC_ONE && prdata[25:17] == 9'h0;
	endproperty
	a_nop: assert property (p_nop) else $error("nop");
	property p_dmv;
		ctl && cls == 4'h8 |-> cyc == `CYC_TWO;
	endproperty
	a_dmv: assert property (p_dmv) else $error("dmove");
	property p_mac;
		ctl && cls == 4'h9 |->
			prdata[25:17] == (prdata[7] ? `AFF_ACC_B : `AFF_ACC_A);
	endproperty
	a_mac: assert property (p_mac) else $error("acc flags");
	property p_br;
		ctl && cls == 4'h2 |-> prdata[16] == prdata[15] &&
			cyc == (prdata[15] ? `CYC_TWO : `CYC_ONE);
	endproperty
	a_br: assert property (p_br) else $error("branch");
	property p_siz;
		ctl |-> prdata[5:4] != 2'h3;
	endproperty
	a_siz: assert property (p_siz) else $error("size");
	cover property (ctl && cls == 4'h9);
	cover property (ctl && cls == 4'h3 && cyc == `CYC_THREE);
	cover property (rd && pslverr);
endmodule // iword_monitor
bind instruction_word_decoder iword_monitor i_iword_monitor (.pclk(pclk),
	.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr));
`default_nettype wire

//--- tb/prog_mem_model.sv
// program memory model: words fed to the decoder in order
// assumes the bench copies each fetched word into the decoder
`timescale 1ns/1ps
`default_nettype none
module prog_mem_model (
	input wire logic [2:0]  addr, // word index
	output logic     [23:0] word  // fetched word
);
	always_comb
	begin
		case (addr)
			3'h0: word = 24'h110000; // skip on carry
			3'h1: word = 24'h020000; // skipped goto
			3'h2: word = 24'h000000;
			3'h3: word = 24'h021234;
			3'h4: word = 24'h000056;
			3'h5: word = 24'h021235; // odd target
			default: word = 24'h000000;
		endcase
	end
endmodule // prog_mem_model
`default_nettype wire

//--- tb/testbench.sv
// self-checking bench for the instruction word decoder
// assumes apb answers with pready; any wait is bounded
`timescale 1ns/1ps
`default_nettype none
`include "iword_defines.vh"
module testbench;
	localparam logic [7:0] ci = `OFS_INSTR;
	localparam logic [7:0] cf = `OFS_FLAGS;
	localparam logic [7:0] cc = `OFS_DEC_CTRL;
	localparam logic [7:0] cp = `OFS_DEC_PADDR;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, q;
	logic [2:0]  pm_addr;
	logic [23:0] pm_word;
	int          num_errors, checked;
	int          fpos [7] = '{0, 4, 2, 3, 1, 5, 6};
	instruction_word_decoder i_instruction_word_decoder (.pclk(pclk),
		.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr));
	prog_mem_model i_prog_mem_model (.addr(pm_addr), .word(pm_word));
	task automatic stop_test;
		$display("errors %0d checks %0d", num_errors, checked);
		if (num_errors == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] s, x);
		checked++;
		if (s !== x)
		begin
			num_errors++;
			$display("MISMATCH %s exp %h seen %h", nm, x, s);
		end
	endtask
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		// pready is sampled at the edge; data taken at that same edge
		do
		begin
			@(posedge pclk);
			if (++n > 20)
			begin
				num_errors++;
				stop_test;
			end
		end
		while (pready !== 1'h1);
		q = prdata;
		e = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'h1, a, d);
	endtask
	task automatic rd(input string nm, input logic [7:0] a,
		input logic [31:0] m, x);
		xfer(1'h0, a, 32'h0);
		chk(nm, q & m, x);
	endtask
	task automatic dec(input logic [23:0] w, input string nm,
		input logic [7:0] a, input logic [31:0] m, x);
		wr(ci, {8'h0, w});
		rd(nm, a, m, x);
	endtask
	task automatic fetch(input logic [2:0] i);
		pm_addr = i;
		#1;
		wr(ci, {8'h0, pm_word});
	endtask
	initial
	begin
		pclk = 1'h0;
		forever #5 pclk = ~pclk;
	end
	initial
	begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		pm_addr = 3'h0;
		num_errors = 0;
		checked = 0;
		repeat (12) @(posedge pclk);
		presetn <= 1'h1;
		rd("ins", ci, '1, 32'h0);
		rd("flg", cf, '1, 32'h0);
		rd("ctl", cc, '1, 32'h0);
		wr(cf, '1);
		rd("flg", cf, '1, 32'h1ff);
		wr(cf, 32'h0);
		dec(24'h2539d2, "3op", cc, 32'h3fe0d7f, 32'h3e0554);
		rd("opd", 8'h0c, 32'h3ffff, 32'h09593);
		dec(24'h200000, "siz", cc, 32'h3f, 32'h4);
		dec(24'h220000, "siz", cc, 32'h3f, 32'h24);
		dec(24'h230000, "sz3", cc, 32'h103f, 32'h1004);
		dec(24'h413fff, "fad", 8'h10, 32'h1fff, 32'h1fff);
		rd("fdst", 8'h0c, 32'h40000, 32'h40000);
		dec(24'h400000, "fdst", 8'h0c, 32'h40000, 32'h0);
		dec(24'h60f000, "bit", 8'h0c, 32'hf80000, 32'h780000);
		dec(24'h615000, "bit", 8'h0c, 32'hf80000, 32'ha80000);
		dec(24'h710ff0, "lit", 8'h10, 32'hffff, 32'hff);
		dec(24'h711000, "ill", cc, 32'h1000, 32'h1000);
		dec(24'h703ff0, "lit", 8'h10, 32'hffff, 32'h3ff);
		dec(24'h722000, "lit", 8'h10, 32'hffff, 32'hfe00);
		dec(24'h080000, "tak", cc, 32'h18c0f, 32'h18802);
		for (int i = 1; i < 8; i++)
		begin
			wr(cf, 32'h1 << fpos[i - 1]);
			dec({5'h01, i[2:0], 16'h0}, "tak", cc, 32'h18c0f, 32'h18802);
			dec({5'h02, i[2:0], 16'h0}, "skp", cc, 32'ha00f, 32'ha003);
			wr(ci, 32'h0);
			rd("sk2", cc, 32'h2c00, 32'h800);
			wr(cf, 32'h0);
			dec({5'h01, i[2:0], 16'h0}, "not", cc, 32'h18c0f, 32'h402);
		end
		dec(24'h060000, "tbl", cc, 32'hc00, 32'h800);
		dec(24'h070000, "psv", cc, 32'hc00, 32'h800);
		dec(24'h780000, "dmv", cc, 32'hc0f, 32'h808);
		wr(cf, 32'h1);
		fetch(3'h0);
		fetch(3'h1);
		rd("bsy", cc, 32'h2000, 32'h2000);
		fetch(3'h2);
		rd("sk3", cc, 32'h2c00, 32'hc00);
		wr(cf, 32'h0);
		fetch(3'h3);
		rd("bsy", cc, 32'h2000, 32'h2000);
		fetch(3'h4);
		rd("gto", cc, 32'h3e00, 32'ha00);
		rd("pad", cp, 32'h7fffff, 32'h561234);
		fetch(3'h5);
		fetch(3'h6);
		rd("odd", cc, 32'h1000, 32'h1000);
		dec(24'h00abcd, "nop", cc, 32'hc0f, 32'h400);
		dec(24'h815262, "mac", cc, 32'h3fe008f, 32'h2800089);
		rd("dsp", 8'h18, 32'hc0180f, 32'h80080e);
		dec(24'h821000, "sq", 8'h18, 32'hf, 32'h5);
		rd("mac", cc, 32'h3fe008f, 32'h1400009);
		dec(24'h800800, "xpf", 8'h18, 32'h7f0, 32'h700);
		dec(24'h818000, "ill", cc, 32'h1000, 32'h1000);
		dec(24'h920000, "shr", 8'h18, 32'h1000000, 32'h1000000);
		wr(cc, '1);
		rd("ro", cc, 32'hf, 32'ha);
		xfer(1'h0, 8'h1c, 32'h0);
		chk("err", {31'h0, e}, 32'h1);
		chk("errd", q, 32'h0);
		stop_test;
	end
endmodule // testbench
`default_nettype wire
